// >>> hdl/ppmc_defs.svh
// constant definitions for the pack power-mode controller
`ifndef PPMC_DEFS_SVH
`define PPMC_DEFS_SVH
`define PPMC_CLK_MHZ 200
`define PPMC_CTRL_ADDR 8'h60
`define PPMC_CTRL_RST 8'h00
`define PPMC_BIT_NBLANK 7
`define PPMC_BIT_LOWCELL 6
`define PPMC_BIT_BUSLOW 5
`define PPMC_BIT_OPSEL 4
`define PPMC_BIT_RSVD0 3
`define PPMC_BIT_PIOWAKE 2
`define PPMC_BIT_LINEWAKE 1
`define PPMC_OPC_NETADDR0 8'h33
`define PPMC_OPC_NETADDR1 8'h39
`define PPMC_RDATA_NONE 8'h00
`define PPMC_T_SLEEP_US 2000
`define PPMC_T_DEBOUNCE_MS 100
`define PPMC_SLEEP_CYC (`PPMC_T_SLEEP_US * `PPMC_CLK_MHZ)
`define PPMC_DEBOUNCE_CYC (`PPMC_T_DEBOUNCE_MS * 1000 * `PPMC_CLK_MHZ)
`endif

// >>> hdl/ppmc_pkg.sv
// types for the pack power-mode controller
package ppmc_pkg;
	typedef enum logic [1:0] {
		PPMC_ACTIVE = 2'b00,
		PPMC_SLEEP_BUS = 2'b01,
		PPMC_SLEEP_LOW = 2'b10
	} ppmc_state_t;
endpackage

// >>> hdl/ppmc_debounce.sv
// wake-switch low-level debounce filter
module ppmc_debounce #(
	parameter int unsigned CYC = 20000000
) (
	input wire logic clk_i,
	input wire logic resetn_i,
	input wire logic armed_i,
	input wire logic level_i,
	output logic wake_o
);
	localparam int W = $clog2(CYC + 1);
	logic [W-1:0] cnt_reg;
	logic seen_high_reg;

	generate
		if (CYC < 1) begin : g_chk
			$error("debounce count must be at least one");
		end
	endgenerate

	// arm only once the pull-up has lifted the pin, so a pin that is
	// already low when sleep begins is not taken for a press
	always_ff @(posedge clk_i or negedge resetn_i) begin
		if (!resetn_i) begin
			seen_high_reg <= 1'b0;
		end else if (!armed_i) begin
			seen_high_reg <= 1'b0;
		end else if (level_i) begin
			seen_high_reg <= 1'b1; // RULE10
		end
	end

	// count while pin held low and armed; any high restarts the window
	always_ff @(posedge clk_i or negedge resetn_i) begin
		if (!resetn_i) begin
			cnt_reg <= '0;
		end else if (!armed_i || level_i || !seen_high_reg) begin
			cnt_reg <= '0; // RULE11
		end else if (cnt_reg != W'(CYC)) begin
			cnt_reg <= cnt_reg + W'(1);
		end
	end

	assign wake_o = armed_i && (cnt_reg == W'(CYC)); // RULE11
endmodule

// >>> hdl/ppmc_top.sv
// power-mode sequencer with control register for the pack gauge
`include "ppmc_defs.svh"

// Behaviour
// [RULE1] power-up lands in Active
// [RULE2] Active enables measurement and hash
// [RULE3] Sleep stops measurement, registers kept
// [RULE4] Sleep forces gates off, refuses hash
// [RULE5] charger or charge current blocks Sleep
// [RULE6] wake on charger with good cell, line rise
// [RULE7] bus-low sleep after qualification if enabled
// [RULE8] low-cell sleep with stable line if enabled
// [RULE9] low-cell sleep wakes on any line change
// [RULE10] wake switch pulls pin high then arms
// [RULE11] wake switch debounced over 100ms
// [RULE12] control loaded from NV, copied on command
// [RULE13] blanking bit enables negative current blanking
// [RULE14] opcode select picks 33h or 39h
// [RULE15] host writes zero to reserved bit 3
// [RULE16] both wake-switch enables work independently
// [RULE17] Sleep entry clears overvoltage flag
// [RULE18] power-up and wake set gate allows
// [RULE19] qualification counter restarts on line change
// [RULE20] either enabled sleep cause suffices
module ppmc_top
	import ppmc_pkg::*;
#(
	parameter int unsigned SLEEP_CYC = `PPMC_SLEEP_CYC,
	parameter int unsigned DEBOUNCE_CYC = `PPMC_DEBOUNCE_CYC
) (
	input wire logic clk_i,
	input wire logic resetn_i,
	input wire logic data_line_i,
	input wire logic programmable_io_pin_i,
	input wire logic charger_detect_i,
	input wire logic charge_current_i,
	input wire logic low_cell_i,
	input wire logic [7:0] reg_addr_i,
	input wire logic reg_wr_i,
	input wire logic reg_rd_i,
	input wire logic [7:0] reg_wdata_i,
	output logic [7:0] reg_rdata_o,
	input wire logic [7:0] nv_ctrl_i,
	input wire logic copy_data_i,
	output logic nv_write_o,
	output logic [7:0] nv_wdata_o,
	input wire logic charge_switch_allow_i,
	input wire logic discharge_switch_allow_i,
	output logic charge_switch_drive_o,
	output logic discharge_switch_drive_o,
	output logic active_o,
	output logic measure_en_o,
	output logic hash_allow_o,
	output logic gate_allow_set_o,
	output logic overvoltage_flag_clear_o,
	output logic line_pullup_o,
	output logic pio_pullup_o,
	output logic negative_blank_enable_o,
	output logic [7:0] net_address_opcode_o
);
	localparam int QW = $clog2(SLEEP_CYC + 1);

	generate
		if (SLEEP_CYC < 1) begin : g_chk
			$error("sleep qualification count must be at least one");
		end
	endgenerate

	ppmc_state_t state_reg, state_next;
	logic [7:0] ctrl_reg;
	logic load_reg;
	logic [1:0] line_s_reg, pio_s_reg, chg_s_reg, cur_s_reg;
	logic line_prev_reg;
	logic [QW-1:0] qual_reg;
	logic qual_done, line_edge, line_rise, block_sleep;
	logic bus_low_cond, low_cell_cond, sleep_cond;
	logic asleep, wake_pio, wake_line, wake_any;
	logic line_sync, pio_sync, chg_sync, cur_sync;

	// two-flop synchronisers for pins and the charger and charge-current comparator levels
	always_ff @(posedge clk_i or negedge resetn_i) begin
		if (!resetn_i) begin
			line_s_reg <= 2'h3;
			pio_s_reg <= 2'h3;
			chg_s_reg <= 2'h0;
			cur_s_reg <= 2'h0;
		end else begin
			line_s_reg <= {line_s_reg[0], data_line_i};
			pio_s_reg <= {pio_s_reg[0], programmable_io_pin_i};
			chg_s_reg <= {chg_s_reg[0], charger_detect_i};
			cur_s_reg <= {cur_s_reg[0], charge_current_i};
		end
	end
	assign line_sync = line_s_reg[1];
	assign pio_sync = pio_s_reg[1];
	assign chg_sync = chg_s_reg[1];
	assign cur_sync = cur_s_reg[1];

	// line edge detection on the synchronised level
	always_ff @(posedge clk_i or negedge resetn_i) begin
		if (!resetn_i) begin
			line_prev_reg <= 1'b1;
		end else begin
			line_prev_reg <= line_sync;
		end
	end
	assign line_edge = line_sync != line_prev_reg;
	assign line_rise = line_sync && !line_prev_reg;

	// qualification timer, restarted by every line change
	always_ff @(posedge clk_i or negedge resetn_i) begin
		if (!resetn_i) begin
			qual_reg <= '0;
		end else if (line_edge) begin
			qual_reg <= '0; // RULE19
		end else if (qual_reg != QW'(SLEEP_CYC)) begin
			qual_reg <= qual_reg + QW'(1);
		end
	end
	assign qual_done = qual_reg == QW'(SLEEP_CYC) && !line_edge;

	// sleep entry conditions
	assign block_sleep = chg_sync || cur_sync; // RULE5
	assign bus_low_cond = ctrl_reg[`PPMC_BIT_BUSLOW] && !line_sync
		&& qual_done; // RULE7
	assign low_cell_cond = ctrl_reg[`PPMC_BIT_LOWCELL] && low_cell_i
		&& qual_done; // RULE8
	assign sleep_cond = (bus_low_cond || low_cell_cond)
		&& !block_sleep; // RULE20

	// wake switches, each pin filtered on its own
	assign asleep = state_reg != PPMC_ACTIVE;
	assign pio_pullup_o = asleep
		&& ctrl_reg[`PPMC_BIT_PIOWAKE]; // RULE10 RULE16
	assign line_pullup_o = asleep
		&& ctrl_reg[`PPMC_BIT_LINEWAKE]; // RULE10 RULE16
	ppmc_debounce #(.CYC(DEBOUNCE_CYC)) u_pio_deb (
		.clk_i(clk_i),
		.resetn_i(resetn_i),
		.armed_i(pio_pullup_o),
		.level_i(pio_sync),
		.wake_o(wake_pio)
	);
	ppmc_debounce #(.CYC(DEBOUNCE_CYC)) u_line_deb (
		.clk_i(clk_i),
		.resetn_i(resetn_i),
		.armed_i(line_pullup_o),
		.level_i(line_sync),
		.wake_o(wake_line)
	);
	assign wake_any = (chg_sync && !low_cell_i) || line_rise
		|| wake_pio || wake_line; // RULE6

	// power-mode sequencer
	always_comb begin
		state_next = state_reg;
		case (state_reg)
			PPMC_ACTIVE: begin
				if (!load_reg && sleep_cond) begin
					state_next = bus_low_cond ? PPMC_SLEEP_BUS
						: PPMC_SLEEP_LOW;
				end
			end
			PPMC_SLEEP_BUS: begin
				if (wake_any) begin
					state_next = PPMC_ACTIVE;
				end
			end
			PPMC_SLEEP_LOW: begin
				if (wake_any || line_edge) begin
					state_next = PPMC_ACTIVE; // RULE9
				end
			end
			default: begin
				state_next = PPMC_ACTIVE;
			end
		endcase
	end

	always_ff @(posedge clk_i or negedge resetn_i) begin
		if (!resetn_i) begin
			state_reg <= PPMC_ACTIVE; // RULE1
		end else begin
			state_reg <= state_next;
		end
	end

	// protection register side effects of mode changes
	always_ff @(posedge clk_i or negedge resetn_i) begin
		if (!resetn_i) begin
			gate_allow_set_o <= 1'b0;
			overvoltage_flag_clear_o <= 1'b0;
		end else begin
			gate_allow_set_o <= load_reg
				|| (asleep && state_next == PPMC_ACTIVE); // RULE18
			overvoltage_flag_clear_o <= !asleep
				&& state_next != PPMC_ACTIVE; // RULE17
		end
	end

	// power-up recall, working-copy writes and register reads
	always_ff @(posedge clk_i or negedge resetn_i) begin
		if (!resetn_i) begin
			load_reg <= 1'b1;
			ctrl_reg <= `PPMC_CTRL_RST;
		end else if (load_reg) begin
			load_reg <= 1'b0;
			ctrl_reg <= nv_ctrl_i; // RULE12
		end else if (reg_wr_i && reg_addr_i == `PPMC_CTRL_ADDR) begin
			ctrl_reg <= reg_wdata_i; // RULE12
		end
	end

	always_ff @(posedge clk_i or negedge resetn_i) begin
		if (!resetn_i) begin
			reg_rdata_o <= `PPMC_RDATA_NONE;
		end else if (reg_rd_i && reg_addr_i == `PPMC_CTRL_ADDR) begin
			reg_rdata_o <= ctrl_reg;
		end else begin
			reg_rdata_o <= `PPMC_RDATA_NONE;
		end
	end

	// copy-data command persists the working copy
	always_ff @(posedge clk_i or negedge resetn_i) begin
		if (!resetn_i) begin
			nv_write_o <= 1'b0;
			nv_wdata_o <= `PPMC_CTRL_RST;
		end else begin
			nv_write_o <= copy_data_i && !load_reg; // RULE12
			if (copy_data_i && !load_reg) begin
				nv_wdata_o <= ctrl_reg;
			end
		end
	end

	// mode-dependent enables and gate drives
	assign active_o = !asleep;
	assign measure_en_o = !asleep; // RULE2 RULE3
	assign hash_allow_o = !asleep; // RULE2 RULE4
	assign charge_switch_drive_o = !asleep
		&& charge_switch_allow_i; // RULE4
	assign discharge_switch_drive_o = !asleep
		&& discharge_switch_allow_i; // RULE4
	assign negative_blank_enable_o = ctrl_reg[`PPMC_BIT_NBLANK]; // RULE13
	assign net_address_opcode_o = ctrl_reg[`PPMC_BIT_OPSEL]
		? `PPMC_OPC_NETADDR1 : `PPMC_OPC_NETADDR0; // RULE14

	// checks
	a_reset_active: assert property (@(posedge clk_i) // RULE1
		$rose(resetn_i) |-> active_o)
		else $error("not active after reset");
	a_sleep_gates: assert property (@(posedge clk_i) // RULE4
		disable iff (!resetn_i) !active_o |->
		!charge_switch_drive_o && !discharge_switch_drive_o
		&& !hash_allow_o && !measure_en_o)
		else $error("gate or hash live in sleep");
	a_block_charger: assert property (@(posedge clk_i) // RULE5
		disable iff (!resetn_i) active_o && block_sleep |=> active_o)
		else $error("sleep entered with charger");
	a_buslow_entry: assert property (@(posedge clk_i) // RULE7
		disable iff (!resetn_i) active_o && !load_reg
		&& bus_low_cond && !block_sleep
		|=> state_reg == PPMC_SLEEP_BUS)
		else $error("bus-low sleep not entered");
	a_uv_wake_edge: assert property (@(posedge clk_i) // RULE9
		disable iff (!resetn_i) state_reg == PPMC_SLEEP_LOW
		&& line_edge |=> active_o)
		else $error("no wake on line change");
	a_line_rise_wake: assert property (@(posedge clk_i) // RULE6
		disable iff (!resetn_i) !active_o && line_rise |=> active_o)
		else $error("no wake on line rise");
	a_ov_clear: assert property (@(posedge clk_i) // RULE17
		disable iff (!resetn_i) $fell(active_o)
		|-> overvoltage_flag_clear_o)
		else $error("overvoltage flag not cleared");
	a_allow_set: assert property (@(posedge clk_i) // RULE18
		disable iff (!resetn_i) $rose(active_o) |-> gate_allow_set_o)
		else $error("gate allows not set on wake");
	a_opcode_sel: assert property (@(posedge clk_i) // RULE14
		disable iff (!resetn_i) !load_reg && reg_wr_i
		&& reg_addr_i == `PPMC_CTRL_ADDR
		|=> net_address_opcode_o
		== ($past(reg_wdata_i[`PPMC_BIT_OPSEL]) ? `PPMC_OPC_NETADDR1
		: `PPMC_OPC_NETADDR0))
		else $error("wrong net address opcode");
	a_qual_restart: assert property (@(posedge clk_i) // RULE19
		disable iff (!resetn_i) line_edge |=> qual_reg == '0)
		else $error("qualification not restarted");
	a_copy_data: assert property (@(posedge clk_i) // RULE12
		disable iff (!resetn_i) copy_data_i && !load_reg
		|=> nv_write_o && nv_wdata_o == $past(ctrl_reg))
		else $error("copy-data did not persist control");
endmodule

// >>> verification/ppmc_host_model.sv
// host-side model: serial line level, register strobes, copy command
module ppmc_host_model (
	input wire logic clk_i,
	output logic line_o,
	output logic [7:0] addr_o,
	output logic wr_o,
	output logic rd_o,
	output logic [7:0] wdata_o,
	output logic copy_o
);
	timeunit 1ns;
	timeprecision 1ps;
	// idle bus, line pulled high by the host
	initial begin
		line_o = 1'b1;
		addr_o = 8'h00;
		wr_o = 1'b0;
		rd_o = 1'b0;
		wdata_o = 8'h00;
		copy_o = 1'b0;
	end
	// one register cycle, strobe held for exactly one edge
	task automatic access(input logic [7:0] a, input logic w,
		input logic [7:0] d);
		@(posedge clk_i);
		addr_o <= a;
		wr_o <= w;
		rd_o <= !w;
		wdata_o <= d & 8'hF7;
		@(posedge clk_i);
		wr_o <= 1'b0;
		rd_o <= 1'b0;
		addr_o <= ~a;
	endtask
	// copy-data command pulse
	task automatic copy();
		@(posedge clk_i);
		copy_o <= 1'b1;
		@(posedge clk_i);
		copy_o <= 1'b0;
	endtask
	// move the serial line to a new level
	task automatic line(input logic v);
		@(posedge clk_i);
		line_o <= v;
	endtask
endmodule

// >>> verification/pack_power_mode_control_bench.sv
// bench for the pack power-mode controller
module pack_power_mode_control_bench;
	timeunit 1ns;
	timeprecision 1ps;
	logic clk_i, resetn_i, charger_detect_i, charge_current_i;
	logic low_cell_i, programmable_io_pin_i, charge_switch_allow_i;
	logic discharge_switch_allow_i, data_line_i, reg_wr_i, reg_rd_i;
	logic [7:0] nv_ctrl_i, reg_addr_i, reg_wdata_i, reg_rdata_o;
	logic [7:0] nv_wdata_o, net_address_opcode_o;
	logic copy_data_i, nv_write_o, active_o, measure_en_o, hash_allow_o;
	logic charge_switch_drive_o, discharge_switch_drive_o;
	logic gate_allow_set_o, overvoltage_flag_clear_o;
	logic line_pullup_o, pio_pullup_o, negative_blank_enable_o;
	int n_errors = 0;
	int samples_checked = 0;
	// control value written, expected opcode
	logic [15:0] rows [5] = '{16'h0033, 16'h8033, 16'h1039, 16'hF639,
		16'h0233};
	ppmc_top #(.SLEEP_CYC(20), .DEBOUNCE_CYC(10)) dut (.clk_i, .resetn_i,
		.data_line_i, .programmable_io_pin_i, .charger_detect_i,
		.charge_current_i, .low_cell_i, .reg_addr_i, .reg_wr_i, .reg_rd_i,
		.reg_wdata_i, .reg_rdata_o, .nv_ctrl_i, .copy_data_i, .nv_write_o,
		.nv_wdata_o, .charge_switch_allow_i, .discharge_switch_allow_i,
		.charge_switch_drive_o, .discharge_switch_drive_o, .active_o,
		.measure_en_o, .hash_allow_o, .gate_allow_set_o,
		.overvoltage_flag_clear_o, .line_pullup_o, .pio_pullup_o,
		.negative_blank_enable_o, .net_address_opcode_o);
	ppmc_host_model host (.clk_i, .line_o(data_line_i), .addr_o(reg_addr_i),
		.wr_o(reg_wr_i), .rd_o(reg_rd_i), .wdata_o(reg_wdata_i),
		.copy_o(copy_data_i));
	// 200 MHz clock
	initial begin
		clk_i = 1'b0;
		forever #2.5 clk_i = ~clk_i;
	end
	task automatic chk(input string n, input logic [7:0] g, e);
		samples_checked++;
		if (g !== e) begin
			n_errors++;
			$display("unexpected %s expected %h seen %h", n, e, g);
		end
	endtask
	task automatic results();
		if (n_errors == 0 && samples_checked > 0) begin
			$display("Simulation passed");
		end else begin
			$display("Simulation failed");
		end
		$finish;
	endtask
	task automatic wr(input logic [7:0] d);
		host.access(8'h60, 1'b1, d);
	endtask
	task automatic rd(input logic [7:0] a, e);
		host.access(a, 1'b0, 8'h00);
		#1;
		chk("rdata", reg_rdata_o, e);
	endtask
	// wait, bounded, for the mode to settle; gives up after 200 cycles
	task automatic wm(input logic e);
		int k;
		k = 0;
		while (active_o !== e && k < 200) begin
			@(posedge clk_i);
			#1;
			k++;
		end
		chk("active", {7'h00, active_o}, {7'h00, e});
	endtask
	task automatic hold(input int n, input logic e);
		repeat (n) @(posedge clk_i);
		#1;
		chk("hold", {7'h00, active_o}, {7'h00, e});
	endtask
	// watchdog well beyond the expected few hundred cycles
	initial begin
		#50000;
		n_errors++;
		results();
	end
	// main sequence
	initial begin
		resetn_i = 1'b0;
		{charger_detect_i, charge_current_i, low_cell_i} = 3'b000;
		programmable_io_pin_i = 1'b1;
		charge_switch_allow_i = 1'b1;
		discharge_switch_allow_i = 1'b1;
		nv_ctrl_i = 8'h90;
		repeat (8) @(posedge clk_i);
		#1 chk("active", {7'h00, active_o}, 8'h01);
		chk("hash", {7'h00, hash_allow_o}, 8'h01);
		chk("meas", {7'h00, measure_en_o}, 8'h01);
		@(posedge clk_i);
		resetn_i <= 1'b1;
		@(posedge clk_i);
		#1 chk("gset", {7'h00, gate_allow_set_o}, 8'h01);
		chk("cdrv", {7'h00, charge_switch_drive_o}, 8'h01);
		chk("ddrv", {7'h00, discharge_switch_drive_o}, 8'h01);
		repeat (2) @(posedge clk_i);
		#1 chk("nblank", {7'h00, negative_blank_enable_o}, 8'h01);
		chk("opcode", net_address_opcode_o, 8'h39);
		rd(8'h60, 8'h90);
		rd(8'h5F, 8'h00);
		foreach (rows[i]) begin
			wr(rows[i][15:8]);
			rd(8'h60, rows[i][15:8]);
			chk("nblank", {7'h00, negative_blank_enable_o},
				{7'h00, rows[i][15]});
			chk("opcode", net_address_opcode_o, rows[i][7:0]);
		end
		host.copy();
		#1 chk("nvwr", {7'h00, nv_write_o}, 8'h01);
		chk("nvdata", nv_wdata_o, 8'h02);
		// bus-low sleep blocked by charger, then by charge current
		wr(8'h24);
		@(posedge clk_i);
		charger_detect_i <= 1'b1;
		host.line(1'b0);
		hold(60, 1'b1);
		@(posedge clk_i);
		charger_detect_i <= 1'b0;
		charge_current_i <= 1'b1;
		hold(60, 1'b1);
		@(posedge clk_i);
		charge_current_i <= 1'b0;
		wm(1'b0);
		chk("ovclr", {7'h00, overvoltage_flag_clear_o}, 8'h01);
		chk("cdrv", {7'h00, charge_switch_drive_o}, 8'h00);
		chk("ddrv", {7'h00, discharge_switch_drive_o}, 8'h00);
		chk("hash", {7'h00, hash_allow_o}, 8'h00);
		chk("meas", {7'h00, measure_en_o}, 8'h00);
		chk("piopu", {7'h00, pio_pullup_o}, 8'h01);
		chk("linepu", {7'h00, line_pullup_o}, 8'h00);
		rd(8'h60, 8'h24);
		@(posedge clk_i);
		charger_detect_i <= 1'b1;
		wm(1'b1);
		@(posedge clk_i);
		charger_detect_i <= 1'b0;
		wm(1'b0);
		// short pio glitch must not wake, a held press must
		@(posedge clk_i);
		programmable_io_pin_i <= 1'b0;
		repeat (5) @(posedge clk_i);
		programmable_io_pin_i <= 1'b1;
		hold(20, 1'b0);
		@(posedge clk_i);
		programmable_io_pin_i <= 1'b0;
		wm(1'b1);
		@(posedge clk_i);
		programmable_io_pin_i <= 1'b1;
		wm(1'b0);
		host.line(1'b1);
		wm(1'b1);
		chk("gset", {7'h00, gate_allow_set_o}, 8'h01);
		// low-cell sleep: line activity restarts qualification
		wr(8'h42);
		@(posedge clk_i);
		low_cell_i <= 1'b1;
		repeat (4) begin
			repeat (14) @(posedge clk_i);
			host.line(!data_line_i);
		end
		hold(1, 1'b1);
		wm(1'b0);
		chk("linepu", {7'h00, line_pullup_o}, 8'h01);
		chk("piopu", {7'h00, pio_pullup_o}, 8'h00);
		// charger alone does not wake while the cell is still low
		@(posedge clk_i);
		charger_detect_i <= 1'b1;
		hold(20, 1'b0);
		host.line(1'b0);
		wm(1'b1);
		@(posedge clk_i);
		low_cell_i <= 1'b0;
		charger_detect_i <= 1'b0;
		hold(60, 1'b1);
		// reset in mid-run reloads the control copy from NV
		@(posedge clk_i);
		resetn_i <= 1'b0;
		nv_ctrl_i <= 8'h10;
		repeat (2) @(posedge clk_i);
		#1 chk("active", {7'h00, active_o}, 8'h01);
		@(posedge clk_i);
		resetn_i <= 1'b1;
		@(posedge clk_i);
		#1 chk("gset", {7'h00, gate_allow_set_o}, 8'h01);
		rd(8'h60, 8'h10);
		chk("opcode", net_address_opcode_o, 8'h39);
		chk("nblank", {7'h00, negative_blank_enable_o}, 8'h00);
		results();
	end
endmodule
